// >>> rtl/cmp_bank_pkg.sv
// Shared constants, field layouts and state types for the comparator register bank.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
package cmp_bank_pkg;

    localparam int CMP_COUNT = 3;
    localparam int APB_ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_MODULE_STATUS = 8'h00;
    localparam logic [7:0] OFS_VREF_CONTROL = 8'h04;
    localparam logic [7:0] OFS_EVENT_CONTROL = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

    // Module status fields
    localparam int POS_HALT_IDLE = 15;
    localparam int POS_EVENT_MIRROR = 8;
    localparam int POS_OUTPUT_MIRROR = 0;

    // Reference control fields
    localparam int POS_REF_PIN_SRC = 10;
    localparam int POS_BANDGAP_SEL = 8;
    localparam int POS_REF_POWER = 7;
    localparam int POS_REF_PIN_OE = 6;
    localparam int POS_REF_RANGE = 5;
    localparam int POS_REF_SUPPLY = 4;
    localparam int POS_REF_LEVEL = 0;
    localparam int REF_CTRL_W = 11;

    // Event control fields: polarity pairs low, write-one-to-clear flags high
    localparam int POS_EVENT_POLARITY = 0;
    localparam int POS_EVENT_FLAG = 8;

    // Reset values
    localparam logic [15:0] RST_MODULE_STATUS = 16'h0000;
    localparam logic [15:0] RST_VREF_CONTROL = 16'h0000;
    localparam logic [15:0] RST_EVENT_CONTROL = 16'h0000;
    localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;

    // Reference tap in units of 1/96 of the source span
    localparam logic [6:0] TAP_FINE_STEP = 7'h04;
    localparam logic [6:0] TAP_COARSE_BASE = 7'h18;
    localparam logic [6:0] TAP_COARSE_STEP = 7'h03;

    // Event polarity codes
    typedef enum logic [1:0] {
        POL_OFF = 2'h0,
        POL_RISE = 2'h1,
        POL_FALL = 2'h2,
        POL_ANY = 2'h3
    } event_polarity_t;

    typedef struct packed {
        logic ref_pin_source_select;
        logic [1:0] bandgap_source_select;
        logic ref_power_enable;
        logic ref_pin_output_enable;
        logic ref_range_select;
        logic ref_supply_select;
        logic [3:0] ref_level_value;
    } ref_ctrl_t;

    typedef struct packed {
        logic [APB_ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic prev_level;
        logic flag;
    } event_state_t;

    typedef struct packed {
        logic [6:0] tap;
    } tap_state_t;

    typedef struct packed {
        logic halt_idle;
        logic [2:0] out_mirror;
        ref_ctrl_t vref;
        logic [5:0] polarity;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic [31:0] rdata;
        logic armed;
    } bank_state_t;

endpackage : cmp_bank_pkg

// >>> rtl/cmp_event_unit.sv
// One comparator's sticky event flag with polarity-selected edge detection.
// Assumes the comparator level is already synchronous to clk.
`timescale 1ns/10ps
module cmp_event_unit
    import cmp_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic run,
    input wire logic [1:0] polarity,
    input wire logic level,
    input wire logic clear,
    output logic trigger,
    output logic flag
);
    event_state_t state_reg;
    event_state_t state_next;
    logic edge_hit;

    always_comb
    begin
        unique case (event_polarity_t'(polarity))
            POL_RISE: edge_hit = level & ~state_reg.prev_level;
            POL_FALL: edge_hit = ~level & state_reg.prev_level;
            POL_ANY: edge_hit = level ^ state_reg.prev_level;
            POL_OFF: edge_hit = 1'b0;
        endcase
        // Once set, further triggers stay blocked until software clears it
        trigger = run & ~state_reg.flag & edge_hit;
        state_next = state_reg;
        state_next.prev_level = level;
        // A trigger in the clearing cycle wins over the clear
        state_next.flag = trigger | (state_reg.flag & ~clear);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            state_reg <= '0;
        else if (ce)
            state_reg <= state_next;
    end

    assign flag = state_reg.flag;

endmodule : cmp_event_unit

// >>> rtl/cmp_status_bank.sv
// APB register bank for three comparators and their programmable reference.
// Assumes comparator levels and idle_mode are synchronous to clk.
`timescale 1ns/10ps
module cmp_status_bank
    import cmp_bank_pkg::*;
// Behaviour
// - With the halt bit set, all comparators stop while the device is idle.
// - Status bits 10..8 mirror the event flags of comparators 3..1.
// - Status bits 2..0 mirror the output levels of comparators 3..1.
// - Status bits 14..11 and 7..3 always read zero.
// - Mirror bits ignore status writes, change by hardware or event-flag clears, and are zero after reset.
// - The reference offers two ranges of sixteen levels each.
// - Reference control bit 5 selects the range.
// - Reference control bit 4 selects supply rails or external reference pins.
// - An event flag sets on its polarity-selected edge and blocks until cleared.
// - Range one spans 0 to 0.625 in 1/24 steps, range zero 0.25 to 0.719 in 1/32.
// - The power bit switches the reference circuit on and off.
#(
    parameter int NUM_CMP = CMP_COUNT
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    input wire logic [2:0] cmp_level,
    input wire logic idle_mode,
    output logic cmp_halt,
    output logic [2:0] cmp_event_flag,
    output ref_ctrl_t ref_ctrl,
    output logic [6:0] ref_tap,
    output logic irq
);

    if (NUM_CMP < 1 || NUM_CMP > CMP_COUNT)
    begin : g_bad_count
        $error("NUM_CMP must lie between 1 and 3");
    end

    bank_state_t state_reg;
    bank_state_t state_next;
    logic [2:0] trig;
    logic [2:0] evt_clear;
    logic [2:0] cmp_present;
    logic halted;
    logic setup;
    logic access;
    logic wr_status;
    logic wr_vref;
    logic wr_event;
    logic wr_clear;
    logic wr_enable;
    logic [15:0] st_merged;
    logic [15:0] vref_merged;
    logic [15:0] pol_merged;

    // Word-aligned offset match for the decoder and error path
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, OFS_MODULE_STATUS) | hit(addr, OFS_VREF_CONTROL)
            | hit(addr, OFS_EVENT_CONTROL) | hit(addr, OFS_IRQ_STATUS)
            | hit(addr, OFS_IRQ_CLEAR) | hit(addr, OFS_IRQ_ENABLE);
    endfunction : mapped

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        merge = old;
        if (strb[0])
            merge[7:0] = wdata[7:0];
        if (strb[1])
            merge[15:8] = wdata[15:8];
    endfunction : merge

    function automatic logic [15:0] status_word(input bank_state_t s, input logic [2:0] f);
        status_word = 16'h0000;
        status_word[POS_HALT_IDLE] = s.halt_idle;
        status_word[POS_EVENT_MIRROR +: 3] = f;
        status_word[POS_OUTPUT_MIRROR +: 3] = s.out_mirror;
    endfunction : status_word

    // Comparators beyond NUM_CMP stay inert
    always_comb
    begin
        for (int i = 0; i < CMP_COUNT; i++)
        begin
            cmp_present[i] = (i < NUM_CMP);
        end
    end

    assign halted = state_reg.halt_idle & idle_mode;
    assign setup = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable & state_reg.armed & ce;

    // Per-register write strobes, valid only in the committing access cycle
    assign wr_status = access & apb_req.pwrite & hit(apb_req.paddr, OFS_MODULE_STATUS);
    assign wr_vref = access & apb_req.pwrite & hit(apb_req.paddr, OFS_VREF_CONTROL);
    assign wr_event = access & apb_req.pwrite & hit(apb_req.paddr, OFS_EVENT_CONTROL);
    assign wr_clear = access & apb_req.pwrite & hit(apb_req.paddr, OFS_IRQ_CLEAR);
    assign wr_enable = access & apb_req.pwrite & hit(apb_req.paddr, OFS_IRQ_ENABLE);

    // Merged images live outside the process, since a function result cannot be sliced
    assign st_merged = merge(status_word(state_reg, cmp_event_flag), apb_req.pwdata,
        apb_req.pstrb);
    assign vref_merged = merge({5'h00, state_reg.vref}, apb_req.pwdata, apb_req.pstrb);
    assign pol_merged = merge({10'h000, state_reg.polarity}, apb_req.pwdata, apb_req.pstrb);

    always_comb
    begin
        evt_clear = 3'h0;
        if (access && apb_req.pwrite && hit(apb_req.paddr, OFS_EVENT_CONTROL)
            && apb_req.pstrb[1])
        begin
            evt_clear = apb_req.pwdata[POS_EVENT_FLAG +: 3];
        end
    end

    for (genvar g = 0; g < CMP_COUNT; g++)
    begin : g_evt
        cmp_event_unit u_evt (
            .clk(clk),
            .rstn(rstn),
            .ce(ce),
            .run(cmp_present[g] & ~halted),
            .polarity(state_reg.polarity[2*g +: 2]),
            .level(cmp_level[g]),
            .clear(evt_clear[g]),
            .trigger(trig[g]),
            .flag(cmp_event_flag[g])
        );
    end

    vref_tap_decoder u_tap (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .ctrl(state_reg.vref),
        .tap(ref_tap)
    );

    always_comb
    begin
        state_next = state_reg;

        // Live output mirror freezes while the comparators are halted
        if (!halted)
            state_next.out_mirror = cmp_level & cmp_present;

        // Sticky interrupt causes; a new event beats a same-cycle clear
        state_next.irq_status = state_reg.irq_status | trig;

        // Read data is latched in the setup cycle so prdata comes from a flop
        if (setup)
        begin
            state_next.armed = 1'b1;
            state_next.rdata = 32'h0000_0000;
            if (hit(apb_req.paddr, OFS_MODULE_STATUS))
            begin
                state_next.rdata[15:0] = status_word(state_reg, cmp_event_flag);
            end
            else if (hit(apb_req.paddr, OFS_VREF_CONTROL))
            begin
                state_next.rdata[REF_CTRL_W-1:0] = state_reg.vref;
            end
            else if (hit(apb_req.paddr, OFS_EVENT_CONTROL))
            begin
                state_next.rdata[POS_EVENT_POLARITY +: 6] = state_reg.polarity;
                state_next.rdata[POS_EVENT_FLAG +: 3] = cmp_event_flag;
            end
            else if (hit(apb_req.paddr, OFS_IRQ_STATUS))
            begin
                state_next.rdata[2:0] = state_reg.irq_status;
            end
            else if (hit(apb_req.paddr, OFS_IRQ_ENABLE))
            begin
                state_next.rdata[2:0] = state_reg.irq_enable;
            end
        end

        if (access)
        begin
            state_next.armed = 1'b0;
        end

        if (wr_status)
        begin
            // Mirror bits ignore software; only the halt bit is kept
            state_next.halt_idle = st_merged[POS_HALT_IDLE];
        end

        if (wr_vref)
        begin
            // Range bit 5, supply bit 4, level bits 3..0
            state_next.vref = ref_ctrl_t'(vref_merged[REF_CTRL_W-1:0]);
        end

        if (wr_event)
        begin
            state_next.polarity = pol_merged[5:0];
        end

        if (wr_clear && apb_req.pstrb[0])
        begin
            state_next.irq_status = (state_reg.irq_status & ~apb_req.pwdata[2:0]) | trig;
        end

        if (wr_enable && apb_req.pstrb[0])
        begin
            state_next.irq_enable = apb_req.pwdata[2:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg <= '0;
            state_reg.vref <= ref_ctrl_t'(RST_VREF_CONTROL[REF_CTRL_W-1:0]);
            state_reg.halt_idle <= RST_MODULE_STATUS[POS_HALT_IDLE];
            state_reg.polarity <= RST_EVENT_CONTROL[5:0];
            state_reg.irq_enable <= RST_IRQ_ENABLE;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    // Zero-wait answer once the setup cycle has been seen with ce high
    always_comb
    begin
        apb_rsp.prdata = state_reg.rdata;
        apb_rsp.pready = access;
        apb_rsp.pslverr = access & ~mapped(apb_req.paddr);
    end

    assign cmp_halt = halted;
    assign ref_ctrl = state_reg.vref;
    assign irq = |(state_reg.irq_status & state_reg.irq_enable);

endmodule : cmp_status_bank

// >>> rtl/vref_tap_decoder.sv
// Turns range and level settings into a registered reference tap in 1/96 units.
// Assumes the analog ladder resolves the tap against the selected supply.
`timescale 1ns/10ps
module vref_tap_decoder
    import cmp_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input ref_ctrl_t ctrl,
    output logic [6:0] tap
);
    tap_state_t state_reg;
    tap_state_t state_next;
    logic [6:0] lvl;

    always_comb
    begin
        lvl = {3'h0, ctrl.ref_level_value};
        state_next = state_reg;
        if (!ctrl.ref_power_enable)
            state_next.tap = 7'h00;
        else if (ctrl.ref_range_select)
            state_next.tap = 7'(lvl * TAP_FINE_STEP);
        else
            state_next.tap = 7'(TAP_COARSE_BASE + lvl * TAP_COARSE_STEP);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            state_reg <= '0;
        else if (ce)
            state_reg <= state_next;
    end

    assign tap = state_reg.tap;

endmodule : vref_tap_decoder

// >>> sim/cmp_status_bank_asserts.sv
// Port-level assertions for the comparator register bank.
// Assumes it is bound to cmp_status_bank, one clock, synchronous active-low reset.
`timescale 1ns/10ps
module cmp_status_bank_asserts
    import cmp_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input apb_req_t apb_req,
    input apb_rsp_t apb_rsp,
    input wire logic [2:0] cmp_level,
    input wire logic idle_mode,
    input wire logic cmp_halt,
    input wire logic [2:0] cmp_event_flag,
    input ref_ctrl_t ref_ctrl,
    input wire logic [6:0] ref_tap,
    input wire logic irq
);
    logic wr;
    logic rd_st;
    logic halt_reg;
    logic [1:0] pol_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    assign wr = apb_rsp.pready && apb_req.pwrite;
    assign rd_st = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == OFS_MODULE_STATUS;
    // Shadows of write-only-visible state, so outputs can be tied to their cause
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            halt_reg <= 1'b0;
            pol_reg <= 2'h0;
        end
        else if (wr && apb_req.paddr == OFS_MODULE_STATUS && apb_req.pstrb[1])
            halt_reg <= apb_req.pwdata[15];
        else if (wr && apb_req.paddr == OFS_EVENT_CONTROL && apb_req.pstrb[0])
            pol_reg <= apb_req.pwdata[1:0];
    end
    property p_halt;
        cmp_halt == (halt_reg && idle_mode);
    endproperty
    a_halt: assert property (p_halt) else $error("halt output wrong");
    property p_freeze;
        cmp_halt && !cmp_event_flag[0] |=> !cmp_event_flag[0];
    endproperty
    a_freeze: assert property (p_freeze) else $error("event while halted");
    property p_rd_zero;
        rd_st |-> (apb_rsp.prdata & 32'hFFFF78F8) == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unused bits set");
    property p_rd_evt;
        rd_st |-> apb_rsp.prdata[10:8] == $past(cmp_event_flag);
    endproperty
    a_rd_evt: assert property (p_rd_evt) else $error("event mirror wrong");
    // The edge detector only compares against a level taken with ce high
    property p_evt;
        ce && $past(ce) && !cmp_halt && ((pol_reg == POL_RISE && $rose(cmp_level[0]))
            || (pol_reg == POL_FALL && $fell(cmp_level[0]))
            || (pol_reg == POL_ANY && $changed(cmp_level[0]))) |=> cmp_event_flag[0];
    endproperty
    a_evt: assert property (p_evt) else $error("event flag not set");
    property p_sticky;
        cmp_event_flag[0] && !(wr && apb_req.paddr == OFS_EVENT_CONTROL && apb_req.pwdata[8])
            |=> cmp_event_flag[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("event flag dropped");
    property p_tap_fine;
        ce && ref_ctrl.ref_power_enable && ref_ctrl.ref_range_select
            |=> ref_tap == 7'($past(ref_ctrl.ref_level_value)) * 7'h04;
    endproperty
    a_tap_fine: assert property (p_tap_fine) else $error("fine tap wrong");
    property p_tap_coarse;
        ce && ref_ctrl.ref_power_enable && !ref_ctrl.ref_range_select
            |=> ref_tap == 7'h18 + 7'($past(ref_ctrl.ref_level_value)) * 7'h03;
    endproperty
    a_tap_coarse: assert property (p_tap_coarse) else $error("coarse tap wrong");
    property p_tap_off;
        ce && !ref_ctrl.ref_power_enable |=> ref_tap == 7'h00;
    endproperty
    a_tap_off: assert property (p_tap_off) else $error("tap while off");
    property p_ctrl;
        wr && apb_req.paddr == OFS_VREF_CONTROL && apb_req.pstrb[1:0] == 2'h3
            |=> ref_ctrl == $past(apb_req.pwdata[10:0]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("reference control wrong");
    c_halt: cover property (cmp_halt);
    c_irq: cover property ($rose(irq));
    c_fine: cover property (ref_ctrl.ref_power_enable && ref_ctrl.ref_range_select);
endmodule : cmp_status_bank_asserts

// >>> sim/comparator_status_and_vref_control_bench.sv
// Self-checking bench for the comparator register bank, driven over APB.
// Assumes package offsets and a 100 MHz clock; the checker is bound below.
`timescale 1ns/10ps
module comparator_status_and_vref_control_bench
    import cmp_bank_pkg::*;
();
    logic clk, rstn, ce, idle_mode, irq, cmp_halt, err;
    logic [2:0] cmp_level, cmp_event_flag;
    logic [6:0] ref_tap;
    logic [31:0] rd;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    ref_ctrl_t ref_ctrl;
    int miscompares = 0, comparisons = 0, cycles = 0;
    int halt, flags, irqst, lvl, old, vref, pol, k, i;
    cmp_status_bank u_dut (.clk(clk), .rstn(rstn), .ce(ce), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .cmp_level(cmp_level), .idle_mode(idle_mode), .cmp_halt(cmp_halt),
        .cmp_event_flag(cmp_event_flag), .ref_ctrl(ref_ctrl), .ref_tap(ref_tap), .irq(irq));
    task finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until pready is seen high for the closing edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge clk);
        apb_req.penable <= 1'b1;
        // pready is looked at with the values that stand at the rising edge
        do
            @(posedge clk);
        while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb
    task settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle
    function int tapf(input int v);
        if (!v[7])
            return 0;
        return v[5] ? 4 * (v & 15) : 24 + 3 * (v & 15);
    endfunction : tapf
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end
    initial
    begin
        void'($urandom(32'h061E));
        rstn = 1'b0;
        ce = 1'b1;
        idle_mode = 1'b0;
        cmp_level = 3'h0;
        apb_req = '0;
        apb_req.pstrb = 4'hF;
        lvl = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        for (i = 0; i < 32; i++)
        begin
            vref = ($urandom & 32'h7D0) | ((i & 16) << 1) | (i & 15);
            apb(1'b1, OFS_VREF_CONTROL, vref | ($urandom & 32'hFFFFF800));
            apb(1'b0, OFS_VREF_CONTROL, 32'h0);
            chk(rd, vref);
            settle;
            chk(ref_ctrl, vref);
            chk(ref_tap, tapf(vref));
        end
        idle_mode <= 1'b1;
        for (k = 0; k < 3; k++)
            for (pol = 1; pol < 4; pol++)
            begin
                apb(1'b1, OFS_EVENT_CONTROL, 32'h700 | (pol << (2 * k)));
                apb(1'b1, OFS_IRQ_CLEAR, 32'h7);
                apb(1'b1, OFS_IRQ_ENABLE, 32'h1 << k);
                flags = 0;
                irqst = 0;
                for (i = 0; i < 2; i++)
                begin
                    old = lvl;
                    lvl = (int'(i == 0) << k) | ($urandom & 7 & ~(1 << k));
                    if ((pol[0] && !old[k] && lvl[k]) || (pol[1] && old[k] && !lvl[k]))
                    begin
                        flags = 1 << k;
                        irqst = 1 << k;
                    end
                    @(posedge clk);
                    cmp_level <= 3'(lvl);
                    settle;
                    chk(cmp_event_flag, flags);
                    chk(irq, irqst != 0);
                    apb(1'b0, OFS_MODULE_STATUS, 32'h0);
                    chk(rd, (flags << 8) | lvl);
                    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
                    chk(rd, irqst);
                end
                apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
                @(negedge clk);
                chk(irq, 0);
            end
        apb(1'b1, OFS_MODULE_STATUS, 32'hFFFFFFFF);
        apb(1'b0, OFS_MODULE_STATUS, 32'h0);
        chk(rd, 32'h8000 | (flags << 8) | lvl);
        chk(cmp_halt, 1);
        apb(1'b1, OFS_EVENT_CONTROL, 32'h7FF);
        @(posedge clk);
        cmp_level <= 3'(lvl ^ 7);
        settle;
        chk(cmp_event_flag, 0);
        apb(1'b0, OFS_MODULE_STATUS, 32'h0);
        chk(rd, 32'h8000 | lvl);
        @(posedge clk);
        cmp_level <= 3'(lvl);
        apb(1'b1, OFS_MODULE_STATUS, 32'h0);
        @(negedge clk);
        chk(cmp_halt, 0);
        // With ce low nothing may move, and the level seen before the freeze is kept
        @(posedge clk);
        ce <= 1'b0;
        cmp_level <= 3'(lvl ^ 7);
        settle;
        chk(cmp_event_flag, 0);
        @(posedge clk);
        ce <= 1'b1;
        cmp_level <= 3'(lvl);
        settle;
        chk(cmp_event_flag, 0);
        finish_test();
    end
endmodule : comparator_status_and_vref_control_bench
bind cmp_status_bank cmp_status_bank_asserts u_chk (.clk(clk), .rstn(rstn), .ce(ce),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .cmp_level(cmp_level), .idle_mode(idle_mode),
    .cmp_halt(cmp_halt), .cmp_event_flag(cmp_event_flag), .ref_ctrl(ref_ctrl),
    .ref_tap(ref_tap), .irq(irq));
